// >>> testbench/rcd_rx_recovery_chk.sv
// checker: port assertions for the receive front end
// assumes divisor 0 wherever samples are counted
module rcd_rx_chk (
  input wire logic                      sys_clk,
  input wire logic                      resetn,
  input wire logic                      receiver_enable,
  input wire logic                      serial_rx_pin,
  input wire logic                      double_speed_select,
  input wire logic [rcd_pkg::DIV_W-1:0] baud_divisor_value,
  input wire logic                      rx_pop,
  input wire logic                      rx_valid_ff,
  input rcd_pkg::rcd_frame_t            rx_frame_ff,
  input wire logic                      busy_ff
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       norm0;
  logic [8:0] busy_cnt_ff;
  assign norm0 = receiver_enable && !double_speed_select && baud_divisor_value == 12'h000;
  // cycles spent inside one frame
  always_ff @(posedge sys_clk)
    if (!resetn || !busy_ff)
      busy_cnt_ff <= 9'h000;
    else
      busy_cnt_ff <= busy_cnt_ff + 9'h001;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_spike;
    $rose(busy_ff) && serial_rx_pin && norm0 ##1 (serial_rx_pin && norm0) [*8];
  endsequence
  sequence s_start;
    $rose(busy_ff) && !serial_rx_pin && norm0 ##1 (!serial_rx_pin && norm0) [*8];
  endsequence
  a_reset_clears:
    assert property (disable iff (1'b0) !resetn |=> !rx_valid_ff && !busy_ff) else $error("reset left state");
  a_disable_flush:
    assert property (!receiver_enable |=> !rx_valid_ff) else $error("buffer kept while disabled");
  a_disable_idle:
    assert property (!receiver_enable |=> !busy_ff) else $error("busy while disabled");
  a_spike_reject:
    assert property (s_spike |-> ##[1:4] !busy_ff) else $error("noise start not dropped");
  a_start_hold:
    assert property (s_start |=> busy_ff [*4]) else $error("valid start dropped");
  a_idle_quiet:
    assert property ((!busy_ff && serial_rx_pin && norm0) [*3] |=> !busy_ff) else $error("start without edge");
  a_head_stands:
    assert property (rx_valid_ff && !rx_pop && receiver_enable |=> rx_valid_ff && $stable(rx_frame_ff))
      else $error("head changed without pop");
  a_busy_bounded:
    assert property (baud_divisor_value == 12'h000 |-> busy_cnt_ff < 9'h0c8) else $error("frame too long");
endmodule

bind rcd_rx_recovery rcd_rx_chk i_rcd_rx_chk (.sys_clk, .resetn, .receiver_enable, .serial_rx_pin,
  .double_speed_select, .baud_divisor_value, .rx_pop, .rx_valid_ff, .rx_frame_ff, .busy_ff);

// >>> testbench/rcd_rx_recovery_tb.sv
// rcd_rx_recovery_tb: self-checking bench for the receive front end
// assumes the sender model on the line and the bound checker
module rcd_rx_recovery_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                      sys_clk;
  logic                      resetn;
  logic                      receiver_enable;
  logic                      serial_rx_pin;
  logic                      double_speed_select;
  logic [rcd_pkg::DIV_W-1:0] baud_divisor_value = 12'h000;
  logic [rcd_pkg::IDX_W-1:0] frame_bits;
  logic                      rx_pop;
  logic                      rx_valid_ff;
  rcd_pkg::rcd_frame_t       rx_frame_ff;
  logic                      busy_ff;
  int                        err_count = 0;
  int                        checked = 0;
  rcd_rx_recovery i_rcd_rx_recovery (.sys_clk, .resetn, .receiver_enable, .serial_rx_pin, .double_speed_select,
    .baud_divisor_value, .frame_bits, .rx_pop, .rx_valid_ff, .rx_frame_ff, .busy_ff);
  rcd_tx_model i_rcd_tx_model (.sys_clk, .line(serial_rx_pin));
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  function automatic logic [11:0] fr(input logic [9:0] d, input int nb, input logic fe, input logic ov);
    return {d & 10'((1 << nb) - 1), fe, ov};
  endfunction
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic pop_chk(input logic [11:0] exp);
    int n;
    n = 0;
    while (rx_valid_ff !== 1'b1 && n < 40)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk({11'h000, rx_valid_ff}, 12'h001);
    chk(rx_frame_ff, exp);
    rx_pop <= 1'b1;
    @(posedge sys_clk);
    rx_pop <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic t_modes;
    int nbs[3] = '{5, 8, 10};
    for (int m = 0; m < 2; m++)
      for (int k = 0; k < 3; k++)
      begin
        double_speed_select <= m[0];
        frame_bits <= 4'(nbs[k]);
        @(posedge sys_clk);
        i_rcd_tx_model.send(10'h35a, nbs[k], m ? 8 : 16, 1'b1, m ? 8 : 16);
        i_rcd_tx_model.idle(4);
        pop_chk(fr(10'h35a, nbs[k], 1'b0, 1'b0));
      end
  endtask
  task automatic t_ferr;
    frame_bits <= 4'h8;
    for (int m = 0; m < 2; m++)
    begin
      double_speed_select <= m[0];
      @(posedge sys_clk);
      i_rcd_tx_model.send(10'h0c3, 8, m ? 8 : 16, 1'b0, m ? 8 : 16);
      i_rcd_tx_model.idle(4);
      pop_chk(fr(10'h0c3, 8, 1'b1, 1'b0));
    end
  endtask
  task automatic t_noise;
    int len[5] = '{1, 8, 9, 4, 5};
    for (int k = 0; k < 5; k++)
    begin
      double_speed_select <= (k > 2);
      @(posedge sys_clk);
      i_rcd_tx_model.spike(len[k]);
      i_rcd_tx_model.idle(200);
      if (len[k] == 9 || len[k] == 5)
        pop_chk(fr(10'h3ff, 8, 1'b0, 1'b0));
      else
        chk({11'h000, rx_valid_ff}, 12'h000);
    end
  endtask
  task automatic t_b2b;
    double_speed_select <= 1'b0;
    @(posedge sys_clk);
    for (int k = 1; k < 4; k++)
      i_rcd_tx_model.send(10'(k), 8, 16, 1'b1, 10);
    i_rcd_tx_model.idle(8);
    pop_chk(fr(10'h001, 8, 1'b0, 1'b0));
    pop_chk(fr(10'h002, 8, 1'b0, 1'b0));
    i_rcd_tx_model.send(10'h044, 8, 16, 1'b1, 16);
    i_rcd_tx_model.idle(4);
    pop_chk(fr(10'h044, 8, 1'b0, 1'b1));
  endtask
  task automatic t_disable;
    i_rcd_tx_model.send(10'h055, 8, 16, 1'b1, 16);
    receiver_enable <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk({10'h000, rx_valid_ff, busy_ff}, 12'h000);
    receiver_enable <= 1'b1;
    i_rcd_tx_model.idle(4);
  endtask
  // sender off by about three percent, tick every second cycle, clamped lengths
  task automatic t_rate;
    int         cpb[2] = '{31, 33};
    logic [3:0] fb[2]  = '{4'h3, 4'hf};
    int         nb[2]  = '{5, 10};
    baud_divisor_value <= 12'h001;
    double_speed_select <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      frame_bits <= fb[k];
      @(posedge sys_clk);
      i_rcd_tx_model.send(10'h2b5, nb[k], cpb[k], 1'b1, cpb[k]);
      i_rcd_tx_model.idle(8);
      pop_chk(fr(10'h2b5, nb[k], 1'b0, 1'b0));
    end
    baud_divisor_value <= 12'h000;
    @(posedge sys_clk);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    resetn = 1'b0;
    receiver_enable = 1'b1;
    double_speed_select = 1'b0;
    frame_bits = 4'h8;
    rx_pop = 1'b0;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk({10'h000, rx_valid_ff, busy_ff}, 12'h000);
    t_modes;
    t_ferr;
    t_noise;
    t_b2b;
    t_disable;
    t_rate;
    end_sim;
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    end_sim;
  end
endmodule

// >>> testbench/rcd_tx_model.sv
// rcd_tx_model: remote sender driving the receive line
// assumes calls start on a rising edge; line idles high
module rcd_tx_model (
  input  wire logic sys_clk,
  output logic      line
);
  timeunit 1ns;
  timeprecision 100ps;
  initial line = 1'b1;
  task automatic send(input logic [9:0] d, input int nb, input int cpb, input logic stp, input int slen);
    line <= 1'b0;
    repeat (cpb) @(posedge sys_clk);
    for (int i = 0; i < nb; i++)
    begin
      line <= d[i];
      repeat (cpb) @(posedge sys_clk);
    end
    line <= stp;
    repeat (slen) @(posedge sys_clk);
  endtask
  task automatic idle(input int n);
    line <= 1'b1;
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic spike(input int n);
    line <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask
endmodule

// >>> verilog/rcd_pkg.sv
// rcd_pkg: constants and types for the asynchronous receive front end
// assumes a single system clock; the serial input is already synchronous
package rcd_pkg;

  localparam int unsigned DATA_W   = 10;
  localparam int unsigned DIV_W    = 12;
  localparam int unsigned SAMP_W   = 5;
  localparam int unsigned IDX_W    = 4;

  localparam logic [SAMP_W-1:0] SAMP_NORM = 5'h10;
  localparam logic [SAMP_W-1:0] SAMP_DBL  = 5'h08;
  localparam logic [SAMP_W-1:0] SF_NORM   = 5'h08;
  localparam logic [SAMP_W-1:0] SF_DBL    = 5'h04;
  localparam logic [SAMP_W-1:0] SM_NORM   = 5'h09;
  localparam logic [SAMP_W-1:0] SM_DBL    = 5'h05;
  localparam logic [SAMP_W-1:0] SAMP_ONE  = 5'h01;

  localparam logic [IDX_W-1:0]  BITS_MIN  = 4'h5;
  localparam logic [IDX_W-1:0]  BITS_MAX  = 4'ha;

  typedef enum logic [2:0] {
    RCD_IDLE  = 3'b001,
    RCD_START = 3'b010,
    RCD_DATA  = 3'b100
  } rcd_state_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              frame_error_flag;
    logic              overrun;
  } rcd_frame_t;

endpackage

// >>> verilog/rcd_rx_buffer.sv
// rcd_rx_buffer: two-entry receive buffer holding frame and status together
// assumes the writer holds wr_valid only one cycle; head comes from a register
module rcd_rx_buffer (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              flush,
  input  wire logic              wr_valid,
  input  rcd_pkg::rcd_frame_t    wr_frame,
  output logic                   wr_ready,
  input  wire logic              rd_pop,
  output logic                   rd_valid_ff,
  output rcd_pkg::rcd_frame_t    rd_frame_ff
);

  rcd_pkg::rcd_frame_t mem_ff [2];
  logic [1:0]          count_ff;
  logic                wr_ptr_ff;
  logic                rd_ptr_ff;
  logic                push;
  logic                pop;
  logic [1:0]          nxt_count;
  logic                nxt_rd_ptr;

  assign wr_ready   = (count_ff != 2'h2);
  assign push       = wr_valid && wr_ready;
  assign pop        = rd_pop && rd_valid_ff;
  assign nxt_rd_ptr = rd_ptr_ff ^ pop;
  assign nxt_count  = count_ff + {1'b0, push} - {1'b0, pop};

  // storage
  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem_ff[wr_ptr_ff] <= wr_frame;
    end
  end

  // pointers and fill level
  always_ff @(posedge sys_clk)
  begin
    if (!resetn || flush)
    begin
      count_ff  <= 2'h0;
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
    end
    else
    begin
      count_ff  <= nxt_count;
      wr_ptr_ff <= wr_ptr_ff ^ push;
      rd_ptr_ff <= nxt_rd_ptr;
    end
  end

  // registered head of buffer
  always_ff @(posedge sys_clk)
  begin
    if (!resetn || flush)
    begin
      rd_valid_ff <= 1'b0;
      rd_frame_ff <= '0;
    end
    else
    begin
      rd_valid_ff <= (nxt_count != 2'h0);
      if (push && (wr_ptr_ff == nxt_rd_ptr))
      begin
        rd_frame_ff <= wr_frame;
      end
      else
      begin
        rd_frame_ff <= mem_ff[nxt_rd_ptr];
      end
    end
  end

endmodule

// >>> verilog/rcd_rx_recovery.sv
// rcd_rx_recovery: start-bit qualification and per-bit majority data recovery
// assumes serial_rx_pin is synchronous to sys_clk and the sender keeps its rate
//
// Functional notes
// - sample at 16x rate, 8x when doubled
// - speed-select one picks double speed
// - falling edge starts detection, sample one
// - normal start vote on samples 8-10
// - double start vote on samples 4-6
// - mostly high start is noise, hunt again
// - accepted start realigns timing every frame
// - per-bit counter of 16 or 8 states
// - bit is majority of three centre samples
// - first vote sample is 8 or 4
// - middle vote sample is 9 or 5
// - recover data, parity, first stop only
// - zero stop bit sets frame error
// - next start accepted right after stop vote
// - five to ten data plus parity bits
// - frame error stored with its frame
// - speed select cuts divisor 16 to 8
module rcd_rx_recovery (
  input  wire logic                        sys_clk,
  input  wire logic                        resetn,
  input  wire logic                        receiver_enable,
  input  wire logic                        serial_rx_pin,
  input  wire logic                        double_speed_select,
  input  wire logic [rcd_pkg::DIV_W-1:0]   baud_divisor_value,
  input  wire logic [rcd_pkg::IDX_W-1:0]   frame_bits,
  input  wire logic                        rx_pop,
  output logic                             rx_valid_ff,
  output rcd_pkg::rcd_frame_t              rx_frame_ff,
  output logic                             busy_ff
);

  rcd_pkg::rcd_state_t           state_ff;
  logic [rcd_pkg::DIV_W-1:0]     div_cnt_ff;
  logic                          tick_ff;
  logic                          rx_prev_ff;
  logic [rcd_pkg::SAMP_W-1:0]    samp_ff;
  logic [rcd_pkg::IDX_W-1:0]     bit_idx_ff;
  logic [1:0]                    votes_ff;
  logic [rcd_pkg::DATA_W-1:0]    shreg_ff;
  logic                          push_ff;
  rcd_pkg::rcd_frame_t           push_frame_ff;
  logic                          overrun_pend_ff;
  logic                          buf_ready;
  logic [rcd_pkg::SAMP_W-1:0]    samp_per_bit;
  logic [rcd_pkg::SAMP_W-1:0]    samp_first;
  logic [rcd_pkg::SAMP_W-1:0]    samp_mid;
  logic [rcd_pkg::SAMP_W-1:0]    samp_last;
  logic [rcd_pkg::IDX_W-1:0]     nbits;
  logic                          voted;

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic [rcd_pkg::IDX_W-1:0] clamp_bits(input logic [rcd_pkg::IDX_W-1:0] n);
    if (n < rcd_pkg::BITS_MIN)
      clamp_bits = rcd_pkg::BITS_MIN;
    else if (n > rcd_pkg::BITS_MAX)
      clamp_bits = rcd_pkg::BITS_MAX;
    else
      clamp_bits = n;
  endfunction

  assign samp_per_bit = double_speed_select ? rcd_pkg::SAMP_DBL : rcd_pkg::SAMP_NORM;
  assign samp_first   = double_speed_select ? rcd_pkg::SF_DBL : rcd_pkg::SF_NORM;
  assign samp_mid     = double_speed_select ? rcd_pkg::SM_DBL : rcd_pkg::SM_NORM;
  assign samp_last    = samp_mid + rcd_pkg::SAMP_ONE;
  assign nbits        = clamp_bits(frame_bits);
  assign voted        = maj3(votes_ff[1], votes_ff[0], serial_rx_pin);

  always_ff @(posedge sys_clk)
  begin
    if (!resetn || !receiver_enable)
    begin
      div_cnt_ff <= '0;
      tick_ff    <= 1'b0;
    end
    else if (div_cnt_ff == '0)
    begin
      div_cnt_ff <= baud_divisor_value;
      tick_ff    <= 1'b1;
    end
    else
    begin
      div_cnt_ff <= div_cnt_ff - 1'b1;
      tick_ff    <= 1'b0;
    end
  end

  // previous line sample for edge hunt
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      rx_prev_ff <= 1'b1;
    end
    else if (tick_ff)
    begin
      rx_prev_ff <= serial_rx_pin;
    end
  end

  // sample state machine
  always_ff @(posedge sys_clk)
  begin
    if (!resetn || !receiver_enable)
    begin
      state_ff      <= rcd_pkg::RCD_IDLE;
      samp_ff       <= '0;
      bit_idx_ff    <= '0;
      votes_ff      <= '0;
      shreg_ff      <= '0;
      push_ff       <= 1'b0;
      push_frame_ff <= '0;
    end
    else
    begin
      push_ff <= 1'b0;
      if (tick_ff)
      begin
        if (samp_ff == samp_first || samp_ff == samp_mid)
        begin
          votes_ff <= {votes_ff[0], serial_rx_pin};
        end
        case (state_ff)
          rcd_pkg::RCD_IDLE:
          begin
            if (rx_prev_ff && !serial_rx_pin)
            begin
              // this tick was sample one, the next is sample two
              state_ff   <= rcd_pkg::RCD_START;
              samp_ff    <= rcd_pkg::SAMP_ONE + rcd_pkg::SAMP_ONE;
              bit_idx_ff <= '0;
              shreg_ff   <= '0;
            end
          end
          rcd_pkg::RCD_START:
          begin
            samp_ff <= samp_ff + rcd_pkg::SAMP_ONE;
            if (samp_ff == samp_last && voted)
            begin
              state_ff <= rcd_pkg::RCD_IDLE;
            end
            else if (samp_ff == samp_per_bit)
            begin
              state_ff <= rcd_pkg::RCD_DATA;
              samp_ff  <= rcd_pkg::SAMP_ONE;
            end
          end
          rcd_pkg::RCD_DATA:
          begin
            samp_ff <= samp_ff + rcd_pkg::SAMP_ONE;
            if (samp_ff == samp_last)
            begin
              if (bit_idx_ff < nbits)
              begin
                shreg_ff[bit_idx_ff] <= voted;
              end
              else
              begin
                state_ff                       <= rcd_pkg::RCD_IDLE;
                push_ff                        <= 1'b1;
                push_frame_ff.data             <= shreg_ff;
                push_frame_ff.frame_error_flag <= !voted;
                push_frame_ff.overrun          <= overrun_pend_ff;
              end
            end
            if (samp_ff == samp_per_bit)
            begin
              samp_ff    <= rcd_pkg::SAMP_ONE;
              bit_idx_ff <= bit_idx_ff + 1'b1;
            end
          end
          default:
          begin
            state_ff <= rcd_pkg::RCD_IDLE;
          end
        endcase
      end
    end
  end

  // lost frame marker for the next stored frame
  always_ff @(posedge sys_clk)
  begin
    if (!resetn || !receiver_enable)
    begin
      overrun_pend_ff <= 1'b0;
    end
    else if (push_ff)
    begin
      overrun_pend_ff <= !buf_ready;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      busy_ff <= 1'b0;
    end
    else
    begin
      busy_ff <= receiver_enable && (state_ff != rcd_pkg::RCD_IDLE);
    end
  end

  rcd_rx_buffer u_buf (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .flush       (!receiver_enable),
    .wr_valid    (push_ff),
    .wr_frame    (push_frame_ff),
    .wr_ready    (buf_ready),
    .rd_pop      (rx_pop),
    .rd_valid_ff (rx_valid_ff),
    .rd_frame_ff (rx_frame_ff)
  );

endmodule
